//--- shared/aci_pkg.sv
// ----------------------------------------------------------------------
// interface register bank constants and carriers
// ----------------------------------------------------------------------
package aci_pkg;

    // register addresses, six bits of the command byte
    localparam logic [5:0] ADDR_STATUS = 6'h00;
    localparam logic [5:0] ADDR_INTERFACE_MODE = 6'h02;
    localparam logic [5:0] ADDR_CHECK = 6'h03;
    localparam logic [5:0] ADDR_RESULT = 6'h04;
    localparam logic [5:0] ADDR_GPIO = 6'h06;
    localparam logic [5:0] ADDR_SETUP = 6'h20;

    // reset values and writable-bit masks
    localparam logic [15:0] INTERFACE_MODE_RST = 16'h0000;
    localparam logic [15:0] INTERFACE_MODE_WMASK = 16'h006D;
    localparam logic [15:0] GPIO_RST = 16'h0800;
    localparam logic [15:0] GPIO_WMASK = 16'h1FFF;
    localparam logic [15:0] SETUP_RST = 16'h0000;
    localparam logic [23:0] CHECK_RST = 24'h000000;
    localparam logic [23:0] RESULT_RST = 24'h000000;

    // field positions
    localparam int IF_SHORT_WORD_SELECT = 0;
    localparam int IF_CHK_LSB = 2;
    localparam int IF_REGCHK = 5;
    localparam int IF_STAT = 6;
    localparam int SETUP_POLAR = 12;
    localparam int ST_RDY = 7;
    localparam int ST_CRCERR = 5;
    localparam int ST_REGERR = 4;
    localparam int CMD_WEN = 7;
    localparam int CMD_RD = 6;

    // checksum-select codes and transfer sizes in bits
    localparam logic [1:0] CHK_OFF = 2'h0;
    localparam logic [1:0] CHK_XOR = 2'h1;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] CHK_BITS = 6'h08;

    // a finished write transfer, handed from the link to the core
    typedef struct packed {
        logic [5:0] addr;
        logic [23:0] data;
        logic ok;
    } aci_wr_s;

    // frozen copy of everything the link may read
    typedef struct packed {
        logic [7:0] status;
        logic [15:0] interface_mode;
        logic [23:0] check;
        logic [23:0] result;
        logic res_short_word_select;
        logic [15:0] gpio;
        logic [15:0] setup;
    } aci_img_s;

endpackage

//--- core/aci_regs.sv
// Function
// RQ1 - nonzero checksum-select adds exactly one checksum byte to every transfer
// RQ2 - select 00 disables checking; 01 appends an xor byte on reads
// RQ3 - with select 01 writes still carry and check the crc byte
// RQ4 - select 10 uses the crc byte on reads and writes
// RQ5 - mode bit 0 picks 24-bit (0) or 16-bit (1) results
// RQ6 - word length change only affects newly produced results, no converter reset
// RQ7 - checksum register at 0x03 is 24-bit xor of user registers
// RQ8 - checksum register reads zero while integrity check is off
// RQ9 - result is offset binary, or straight binary when unipolar selected
// RQ10 - reading result register at 0x04 raises ready flag and pin
// RQ11 - result register keeps its value across repeated reads
// RQ12 - no new result is stored while the result register is read
// RQ13 - status-append makes a result read return status after the data
// RQ14 - 16-bit length rounds the result to 16 bits
// RQ15 - gpio register at 0x06 resets to 0x0800, bits 15:13 read zero
// RQ16 - checksum and result registers reset to zero and are read-only
// RQ17 - checked register change sets register error; clearing check clears it
// RQ18 - mode bit 6 enables status-append, reset disabled
// RQ19 - select 11 behaves as crc mode
`timescale 1ns/1ps
module aci_regs
    import aci_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_din,
    input wire logic i_conv_valid,
    input wire logic [23:0] i_conv_data,
    output logic o_dout,
    output logic o_rdy_b,
    output logic [15:0] o_gpio_cfg
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_b;
    logic [5:0] bit_cnt_q;
    logic [7:0] cmd_q;
    logic [23:0] sh_q;
    logic [7:0] crc_q;
    logic [7:0] xor_q;
    aci_wr_s wr_q;
    logic wr_tgl_q;
    logic rd_tgl_q;
    logic st_tgl_q;
    logic [7:0] cmd_next;
    logic cmd_full;
    logic is_rd;
    logic [5:0] k;
    logic [5:0] nbits;
    logic chk_on;
    logic use_xor;
    logic [5:0] total;
    logic [31:0] rd_word;
    logic tx_bit;
    logic in_bit;
    logic [1:0] cs_sync_q;
    logic frame_act;
    logic [2:0] t1_q;
    logic [2:0] t2_q;
    logic [2:0] t3_q;
    logic wr_pulse;
    logic rd_pulse;
    logic st_pulse;
    logic [15:0] interface_mode_q;
    logic [15:0] gpio_q;
    logic [15:0] setup_q;
    logic [23:0] check_q;
    logic [23:0] snap_q;
    logic [23:0] live_chk;
    logic [23:0] pend_q;
    logic pend_v_q;
    logic pend_wl_q;
    logic [23:0] result_q;
    logic res_wl_q;
    logic rdy_b_q;
    logic crc_err_q;
    logic reg_err_q;
    logic move;
    aci_img_s img_q;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // one bit of crc-8, polynomial x^8+x^2+x+1
    function automatic logic [7:0] crc_step(input logic [7:0] acc, input logic b);
        crc_step = {acc[6:0], 1'b0} ^ ((acc[7] ^ b) ? CRC_POLY : 8'h00);
    endfunction

    // payload length in bits for a register address
    function automatic logic [5:0] xfer_bits(input logic [5:0] a, input aci_img_s im);
        logic [5:0] n;
        n = 6'h10;
        if (a == ADDR_STATUS) begin
            n = 6'h08;
        end else if (a == ADDR_CHECK) begin
            n = 6'h18;
        end else if (a == ADDR_RESULT) begin
            n = (im.res_short_word_select ? 6'h10 : 6'h18) + (im.interface_mode[IF_STAT] ? 6'h08 : 6'h00); // [RQ13]
        end
        xfer_bits = n;
    endfunction

    // read payload, left aligned
    function automatic logic [31:0] read_word(input logic [5:0] a, input aci_img_s im);
        logic [31:0] w;
        w = 32'h00000000;
        unique case (a)
            ADDR_STATUS: w = {im.status, 24'h000000};
            ADDR_INTERFACE_MODE: w = {im.interface_mode, 16'h0000};
            ADDR_CHECK: w = {im.check, 8'h00};
            ADDR_RESULT: begin
                // status byte follows the data when appended [RQ13]
                if (im.res_short_word_select) begin
                    w = {im.result[15:0], im.status, 8'h00};
                end else begin
                    w = {im.result, im.status};
                end
            end
            ADDR_GPIO: w = {im.gpio, 16'h0000};
            ADDR_SETUP: w = {im.setup, 16'h0000};
            default: w = 32'h00000000;
        endcase
        read_word = w;
    endfunction

    // coding and rounding of a fresh conversion
    function automatic logic [23:0] fmt_result(input logic [23:0] d, input logic unip,
                                               input logic short_word_select);
        logic [23:0] v;
        logic [15:0] r;
        v = unip ? (d[23] ? 24'h000000 : {d[22:0], 1'b0}) : {~d[23], d[22:0]}; // [RQ9]
        r = (v[23:8] == 16'hFFFF) ? 16'hFFFF : v[23:8] + {15'h0000, v[7]};
        fmt_result = short_word_select ? {8'h00, r} : v; // [RQ14]
    endfunction

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    // ------------------------------------------------------------------
    // link side, serial clock domain
    // ------------------------------------------------------------------
    // transfer decode from the frozen image
    assign cmd_next = {cmd_q[6:0], i_din};
    assign cmd_full = bit_cnt_q >= CMD_BITS;
    assign is_rd = cmd_q[CMD_RD];
    assign k = bit_cnt_q - CMD_BITS;
    assign nbits = xfer_bits(cmd_q[5:0], img_q);
    assign chk_on = img_q.interface_mode[IF_CHK_LSB+:2] != CHK_OFF; // [RQ1] [RQ2]
    assign use_xor = is_rd && (img_q.interface_mode[IF_CHK_LSB+:2] == CHK_XOR); // [RQ2] [RQ3] [RQ4] [RQ19]
    assign total = CMD_BITS + nbits + (chk_on ? CHK_BITS : 6'h00); // [RQ1]
    assign rd_word = read_word(cmd_q[5:0], img_q);

    // outgoing bit: payload, then the checksum byte
    always_comb begin
        tx_bit = 1'b0;
        if (k < nbits) begin
            tx_bit = rd_word[~k[4:0]];
        end else if (chk_on && k < nbits + CHK_BITS) begin
            tx_bit = use_xor ? xor_q[~k[2:0]] : crc_q[~k[2:0]]; // [RQ2] [RQ4]
        end
    end
    assign in_bit = (cmd_full && is_rd) ? tx_bit : i_din;

    // shift and checksum accumulation, cleared by deselect
    always_ff @(posedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            bit_cnt_q <= 6'h00;
            cmd_q <= 8'h00;
            sh_q <= 24'h000000;
            crc_q <= 8'h00;
            xor_q <= 8'h00;
        end else begin
            if (bit_cnt_q != 6'h3F) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            if (!cmd_full) begin
                cmd_q <= cmd_next;
            end else if (!is_rd && k < nbits) begin
                sh_q <= {sh_q[22:0], i_din};
            end
            if (!cmd_full || !is_rd || k < nbits) begin
                crc_q <= crc_step(crc_q, in_bit);
                xor_q[~bit_cnt_q[2:0]] <= xor_q[~bit_cnt_q[2:0]] ^ in_bit;
            end
        end
    end

    // finished writes and read starts, signalled by toggles
    always_ff @(posedge i_sclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            wr_tgl_q <= 1'b0;
            rd_tgl_q <= 1'b0;
            st_tgl_q <= 1'b0;
        end else if (!i_cs_b) begin
            if (cmd_full && !cmd_q[CMD_WEN] && !is_rd && bit_cnt_q == total - 6'h01) begin
                wr_q.addr <= cmd_q[5:0];
                wr_q.data <= chk_on ? sh_q : {sh_q[22:0], i_din};
                wr_q.ok <= !chk_on || crc_step(crc_q, i_din) == 8'h00; // [RQ3] [RQ4]
                wr_tgl_q <= ~wr_tgl_q;
            end
            if (bit_cnt_q == CMD_BITS - 6'h01 && !cmd_next[CMD_WEN] && cmd_next[CMD_RD]) begin
                if (cmd_next[5:0] == ADDR_RESULT) begin
                    rd_tgl_q <= ~rd_tgl_q;
                end
                if (cmd_next[5:0] == ADDR_STATUS) begin
                    st_tgl_q <= ~st_tgl_q;
                end
            end
        end
    end

    // data out changes on the falling edge
    always_ff @(negedge i_sclk or negedge rst_b) begin
        if (!rst_b) begin
            o_dout <= 1'b0;
        end else begin
            o_dout <= !i_cs_b && cmd_full && is_rd && !cmd_q[CMD_WEN] && tx_bit;
        end
    end

    // ------------------------------------------------------------------
    // crossings into the core clock domain
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_q <= 2'b11;
            t1_q <= 3'b000;
            t2_q <= 3'b000;
            t3_q <= 3'b000;
        end else if (i_ce) begin
            cs_sync_q <= {cs_sync_q[0], i_cs_b};
            t1_q <= {wr_tgl_q, rd_tgl_q, st_tgl_q};
            t2_q <= t1_q;
            t3_q <= t2_q;
        end
    end
    assign frame_act = !cs_sync_q[1];
    assign wr_pulse = t2_q[2] ^ t3_q[2];
    assign rd_pulse = t2_q[1] ^ t3_q[1];
    assign st_pulse = t2_q[0] ^ t3_q[0];

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    // checksum and result have no write path [RQ16]
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            interface_mode_q <= INTERFACE_MODE_RST; // [RQ18]
            gpio_q <= GPIO_RST; // [RQ15]
            setup_q <= SETUP_RST;
        end else if (i_ce && wr_pulse && wr_q.ok) begin
            if (wr_q.addr == ADDR_INTERFACE_MODE) begin
                interface_mode_q <= wr_q.data[15:0] & INTERFACE_MODE_WMASK;
            end
            if (wr_q.addr == ADDR_GPIO) begin
                gpio_q <= wr_q.data[15:0] & GPIO_WMASK; // [RQ15]
            end
            if (wr_q.addr == ADDR_SETUP) begin
                setup_q <= wr_q.data[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // integrity checker
    // ------------------------------------------------------------------
    assign live_chk = {8'h00, gpio_q} ^ {8'h00, setup_q}; // [RQ7]

    // snapshot while disarmed, compare while armed
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            check_q <= CHECK_RST; // [RQ16]
            snap_q <= CHECK_RST;
            reg_err_q <= 1'b0;
        end else if (i_ce) begin
            check_q <= interface_mode_q[IF_REGCHK] ? live_chk : 24'h000000; // [RQ7] [RQ8]
            if (!interface_mode_q[IF_REGCHK]) begin
                snap_q <= live_chk;
                reg_err_q <= 1'b0; // [RQ17]
            end else if (live_chk != snap_q) begin
                reg_err_q <= 1'b1; // [RQ17]
            end
        end
    end

    // write checksum failure, cleared by a status read, set wins
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_err_q <= 1'b0;
        end else if (i_ce) begin
            if (wr_pulse && !wr_q.ok) begin
                crc_err_q <= 1'b1; // [RQ3]
            end else if (st_pulse) begin
                crc_err_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // conversion result and ready flag
    // ------------------------------------------------------------------
    assign move = pend_v_q && !frame_act; // [RQ12]

    // a new result is formatted with the length in force when it arrives
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= RESULT_RST;
            pend_v_q <= 1'b0;
            pend_wl_q <= 1'b0;
        end else if (i_ce) begin
            if (i_conv_valid) begin
                pend_q <= fmt_result(i_conv_data, setup_q[SETUP_POLAR], interface_mode_q[IF_SHORT_WORD_SELECT]); // [RQ5] [RQ6]
                pend_wl_q <= interface_mode_q[IF_SHORT_WORD_SELECT]; // [RQ6]
                pend_v_q <= 1'b1;
            end else if (move) begin
                pend_v_q <= 1'b0;
            end
        end
    end

    // result held through any frame, unchanged by reads
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            result_q <= RESULT_RST; // [RQ16]
            res_wl_q <= 1'b0;
        end else if (i_ce && move) begin
            result_q <= pend_q; // [RQ11] [RQ12]
            res_wl_q <= pend_wl_q;
        end
    end

    // ready goes low on a new result, high when the result is read
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_b_q <= 1'b1;
        end else if (i_ce) begin
            if (move) begin
                rdy_b_q <= 1'b0;
            end else if (rd_pulse) begin
                rdy_b_q <= 1'b1; // [RQ10]
            end
        end
    end

    // ------------------------------------------------------------------
    // read image, frozen while the link is selected
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            img_q <= '0;
            img_q.gpio <= GPIO_RST;
            img_q.status <= 8'h80;
        end else if (i_ce && !frame_act) begin
            img_q.status <= {rdy_b_q, 1'b0, crc_err_q, reg_err_q, 4'h0};
            img_q.interface_mode <= interface_mode_q;
            img_q.check <= check_q;
            img_q.result <= result_q;
            img_q.res_short_word_select <= res_wl_q;
            img_q.gpio <= gpio_q;
            img_q.setup <= setup_q;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_rdy_b <= 1'b1;
            o_gpio_cfg <= GPIO_RST;
        end else if (i_ce) begin
            o_rdy_b <= rdy_b_q; // [RQ10]
            o_gpio_cfg <= gpio_q;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_b || !i_ce);

    a_ready_on_read: assert property (rd_pulse && !move |=> rdy_b_q ##1 o_rdy_b) // [RQ10]
        else $error("ready not raised by result read");
    a_result_frozen: assert property (frame_act |=> $stable(result_q)) // [RQ12]
        else $error("result changed during a frame");
    a_image_frozen: assert property (frame_act |=> $stable(img_q.result)) // [RQ11]
        else $error("read image changed during a frame");
    a_check_zero: assert property (!interface_mode_q[IF_REGCHK] |=> check_q == 24'h000000) // [RQ8]
        else $error("checksum not zero while disabled");
    a_check_value: assert property (interface_mode_q[IF_REGCHK] |=> check_q == $past(live_chk)) // [RQ7]
        else $error("checksum does not match user registers");
    a_gpio_reserved: assert property (gpio_q[15:13] == 3'b000) // [RQ15]
        else $error("gpio reserved bits nonzero");
    a_regerr_clear: assert property (!interface_mode_q[IF_REGCHK] |=> !reg_err_q) // [RQ17]
        else $error("register error not cleared");
    a_regerr_set: assert property (interface_mode_q[IF_REGCHK] && live_chk != snap_q |=> reg_err_q) // [RQ17]
        else $error("register change not flagged");
    a_bad_write: assert property (wr_pulse && !wr_q.ok |=> crc_err_q && $stable(interface_mode_q)) // [RQ3]
        else $error("bad checksum write accepted");
    a_word_len: assert property (i_conv_valid |=> pend_wl_q == $past(interface_mode_q[IF_SHORT_WORD_SELECT])) // [RQ6]
        else $error("result length not taken at arrival");
    a_short_round: assert property (i_conv_valid && interface_mode_q[IF_SHORT_WORD_SELECT] |=> pend_q[23:16] == 8'h00) // [RQ14]
        else $error("short result not rounded");
    a_offset_bin: assert property (i_conv_valid && !setup_q[SETUP_POLAR] && !interface_mode_q[IF_SHORT_WORD_SELECT]
        |=> pend_q[23] == !$past(i_conv_data[23])) // [RQ9]
        else $error("offset binary coding wrong");

    c_result_read: cover property (rd_pulse ##[1:4] rdy_b_q);
    c_held_result: cover property (frame_act && pend_v_q ##1 !frame_act ##1 !rdy_b_q);
    c_reg_error: cover property (interface_mode_q[IF_REGCHK] ##1 reg_err_q);
    c_bad_write: cover property (wr_pulse && !wr_q.ok);

endmodule

//--- tb/aci_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// serial host on the far side of the register link
// ----------------------------------------------------------------------
module aci_host_model (
    output logic o_sclk,
    output logic o_cs_b,
    output logic o_din,
    input wire logic i_dout
);
    // link idles deselected with the clock parked high
    initial begin
        o_sclk = 1'b1;
        o_cs_b = 1'b1;
        o_din = 1'b0;
    end

    // one frame of n bits, msb first, 64 ns link clock only inside the frame
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        o_cs_b = 1'b0;
        #103;
        for (int i = n - 1; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_din = tx[i];
            #32;
            o_sclk = 1'b1;
            rx = {rx[46:0], i_dout};
            #32;
        end
        o_cs_b = 1'b1;
        o_din = ~o_din; // released line shows no stale level
        #200;
    endtask
endmodule

//--- tb/aci_regs_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// register bank bench
// ----------------------------------------------------------------------
module aci_regs_tb;
    import aci_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic conv_valid = 1'b0;
    logic [23:0] conv_data = 24'h000000;
    logic sclk, cs_b, din, dout, rdy_b;
    logic [15:0] gpio_cfg;
    logic [1:0] mode = 2'h0;
    logic ce = 1'b1;
    int err_count = 0;
    int checks_done = 0;

    always #10 clk = ~clk;

    aci_regs i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_sclk(sclk), .i_cs_b(cs_b),
        .i_din(din), .i_conv_valid(conv_valid), .i_conv_data(conv_data), .o_dout(dout),
        .o_rdy_b(rdy_b), .o_gpio_cfg(gpio_cfg));
    aci_host_model i_host (.o_sclk(sclk), .o_cs_b(cs_b), .o_din(din), .i_dout(dout));

    // crc-8 and bytewise xor over a right-aligned bit stream
    function automatic logic [7:0] crc8(input logic [47:0] v, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = n - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction
    function automatic logic [7:0] xsum(input logic [47:0] v, input int n);
        logic [7:0] x;
        x = 8'h00;
        for (int i = 0; i < n; i += 8) begin
            x ^= v[i +: 8];
        end
        return x;
    endfunction

    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // write frame, crc byte appended (or spoiled) while checking is on
    task automatic wr(input logic [5:0] a, input logic [23:0] d, input int n, input logic bad);
        logic [47:0] v, rx;
        v = (48'({2'b00, a}) << n) | 48'(d);
        if (mode != CHK_OFF) begin
            v = {v[39:0], crc8(v, n + 8) ^ {7'h00, bad}};
            n += 8;
        end
        i_host.xfer(v, n + 8, rx);
    endtask

    // read frame, expected checksum byte worked out from the mode
    task automatic rd(input string name, input logic [5:0] a, input int n, input logic [31:0] e);
        logic [47:0] v, rx;
        int t;
        t = n;
        v = (48'({2'b01, a}) << n) | 48'(e);
        if (mode != CHK_OFF) begin
            v = {v[39:0], (mode == CHK_XOR) ? xsum(v, n + 8) : crc8(v, n + 8)};
            t = n + 8;
        end
        i_host.xfer(48'({2'b01, a}) << t, t + 8, rx);
        chk(name, v & ((48'h1 << t) - 48'h1), rx);
    endtask

    // one raw conversion pulse, then time for it to reach the result
    task automatic conv(input logic [23:0] d);
        @(negedge clk);
        conv_valid = 1'b1;
        conv_data = d;
        @(negedge clk);
        conv_valid = 1'b0;
        repeat (6) @(negedge clk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog, well past the expected run of some 90 us
    initial begin
        #1000000;
        err_count++;
        $display("mismatch watchdog expected done seen timeout");
        finish_test();
    end

    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
        chk("gpio pin", 48'(GPIO_RST), 48'(gpio_cfg));
        chk("ready pin", 48'h1, 48'(rdy_b));
        rd("gpio", ADDR_GPIO, 16, 32'h0800);
        rd("interface_mode", ADDR_INTERFACE_MODE, 16, 32'h0000);
        rd("checksum", ADDR_CHECK, 24, 32'h0);
        rd("result", ADDR_RESULT, 24, 32'h0);
        wr(ADDR_GPIO, 24'hFFFF, 16, 1'b0);
        wr(ADDR_RESULT, 24'hABCDEF, 24, 1'b0);
        rd("gpio", ADDR_GPIO, 16, 32'h1FFF);
        chk("gpio pin", 48'h1FFF, 48'(gpio_cfg));
        rd("result", ADDR_RESULT, 24, 32'h0);
        $display("test reset and access done");
        // a conversion offered while the core is frozen is never taken
        @(negedge clk);
        ce = 1'b0;
        conv(24'h7FFFFF);
        chk("ready pin", 48'h1, 48'(rdy_b));
        ce = 1'b1;
        repeat (6) @(negedge clk);
        chk("ready pin", 48'h1, 48'(rdy_b));
        $display("test clock enable done");
        conv(24'h123456);
        chk("ready pin", 48'h0, 48'(rdy_b));
        rd("result", ADDR_RESULT, 24, 32'h923456);
        chk("ready pin", 48'h1, 48'(rdy_b));
        fork
            rd("result", ADDR_RESULT, 24, 32'h923456);
            begin
                #400;
                conv(24'h400000);
            end
        join
        rd("result", ADDR_RESULT, 24, 32'hC00000);
        wr(ADDR_SETUP, 24'h1000, 16, 1'b0);
        conv(24'h800000);
        rd("result", ADDR_RESULT, 24, 32'h0);
        conv(24'h1234C0);
        rd("result", ADDR_RESULT, 24, 32'h246980);
        $display("test result coding done");
        wr(ADDR_INTERFACE_MODE, 24'h0001, 16, 1'b0);
        rd("result", ADDR_RESULT, 24, 32'h246980);
        conv(24'h1234C0);
        rd("result", ADDR_RESULT, 16, 32'h246A);
        wr(ADDR_INTERFACE_MODE, 24'h0041, 16, 1'b0);
        rd("result", ADDR_RESULT, 24, 32'h246A80);
        $display("test word length done");
        wr(ADDR_INTERFACE_MODE, 24'h0020, 16, 1'b0);
        rd("checksum", ADDR_CHECK, 24, 32'h0FFF);
        wr(ADDR_GPIO, 24'h0123, 16, 1'b0);
        wr(ADDR_CHECK, 24'hABCDEF, 24, 1'b0);
        rd("checksum", ADDR_CHECK, 24, 32'h1123);
        rd("status", ADDR_STATUS, 8, 32'h90);
        wr(ADDR_INTERFACE_MODE, 24'h0000, 16, 1'b0);
        rd("status", ADDR_STATUS, 8, 32'h80);
        rd("checksum", ADDR_CHECK, 24, 32'h0);
        $display("test register check done");
        wr(ADDR_INTERFACE_MODE, 24'h0004, 16, 1'b0);
        mode = CHK_XOR;
        rd("gpio", ADDR_GPIO, 16, 32'h0123);
        wr(ADDR_GPIO, 24'h0456, 16, 1'b0);
        rd("gpio", ADDR_GPIO, 16, 32'h0456);
        for (int m = 2; m < 4; m++) begin
            wr(ADDR_INTERFACE_MODE, 24'(m << 2), 16, 1'b0);
            mode = 2'(m);
            wr(ADDR_GPIO, 24'h0777, 16, 1'b1);
            rd("gpio", ADDR_GPIO, 16, 32'h0456);
            rd("status", ADDR_STATUS, 8, 32'hA0);
        end
        wr(ADDR_INTERFACE_MODE, 24'h0000, 16, 1'b0);
        mode = CHK_OFF;
        rd("gpio", ADDR_GPIO, 16, 32'h0456);
        $display("test checksum modes done");
        finish_test();
    end
endmodule
